// ===== bench/fpsvh_top_test.sv
// fpsvh_top_test: self-checking bench for the special-value handler
// assumes a single 250 MHz clock; drives register port and datapath directly
`timescale 1ns/1ps
`default_nettype none

module fpsvh_top_test;
    logic                        clk_i = 1'b0;
    logic                        rst_b_i = 1'b0;
    logic [fpsvh_pkg::ADDR_W-1:0] reg_addr_i = '0;
    logic [fpsvh_pkg::DATA_W-1:0] reg_wdata_i = '0;
    logic                        reg_wr_i = 1'b0;
    logic                        reg_rd_i = 1'b0;
    logic [fpsvh_pkg::DATA_W-1:0] reg_rdata_o;
    logic                        req_valid_i = 1'b0;
    fpsvh_pkg::fpsvh_req_t       req_i = '0;
    logic                        rsp_valid_o;
    fpsvh_pkg::fpsvh_rsp_t       rsp_o;
    logic                        irq_o;
    int                          err_total = 0;
    int                          checks = 0;

    fpsvh_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i),
        .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .irq_o(irq_o));

    always #2 clk_i = ~clk_i;

    // --------------------------------------------------------------
    // bus tasks and expectations
    // --------------------------------------------------------------
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic send(input fpsvh_pkg::fpsvh_req_t r);
        @(posedge clk_i);
        req_valid_i <= 1'b1; req_i <= r;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1 chk(rsp_valid_o, 1'b1);
    endtask

    function automatic fpsvh_pkg::fpsvh_treal_t rnd_nan(input logic s);
        return {s, fpsvh_pkg::EXP_ONES, 1'b1, 31'($urandom()), $urandom() | 32'h1};
    endfunction

    // directed rounding overflow: infinity when the direction points away from zero
    // an unnormal keeps its significand unless infinity is due
    function automatic fpsvh_pkg::fpsvh_treal_t ovf_res(input logic up, input logic s, input logic [63:0] sig);
        if (up != s) return {s, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_INF};
        if (!sig[63]) return {s, fpsvh_pkg::EXP_MAXF, sig};
        return {s, fpsvh_pkg::EXP_MAXF, fpsvh_pkg::SIG_MAXF};
    endfunction

    function automatic logic [63:0] int_min(input logic [1:0] sz);
        return (sz == 2'd0) ? 64'h8000 : (sz == 2'd1) ? 64'h8000_0000 : 64'h8000_0000_0000_0000;
    endfunction

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        #100000;
        err_total++;
        end_sim();
    end

    initial begin
        fpsvh_pkg::fpsvh_req_t r;
        fpsvh_pkg::fpsvh_treal_t na;
        fpsvh_pkg::fpsvh_treal_t nb;
        logic [31:0] d;
        logic [1:0] sz;
        void'($urandom(32'h1583));
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(fpsvh_pkg::OFS_MASK, d); chk(d[5:0], fpsvh_pkg::MASK_RESET);
        rd(fpsvh_pkg::OFS_STATUS, d); chk(d, 32'h0);
        rd(4'hf, d); chk(d, 32'h0);
        for (int i = 0; i < 6; i++) begin
            r = '0; r.op = fpsvh_pkg::FPSVH_OP_ARITH; na = rnd_nan(i[0]); nb = rnd_nan(~i[0]);
            r.a = na; r.b = (i < 3) ? {1'b0, 15'h3fff, 64'h8000_0000_0000_0000} : nb; r.two_ops = 1'b1;
            send(r);
            chk(rsp_o.res, (i < 3 || na[78:0] > nb[78:0]) ? na : nb);
            rd(fpsvh_pkg::OFS_STATUS, d); chk(d[0], 1'b1);
            wr(fpsvh_pkg::OFS_STATUS, 32'h3f);
        end
        for (int i = 0; i < 3; i++) begin
            r = '0; r.a = {1'b0, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_INF}; r.int_in = 64'h8000_0000_0000_0000;
            r.op = (i == 0) ? fpsvh_pkg::FPSVH_OP_ARITH : (i == 1) ? fpsvh_pkg::FPSVH_OP_LOAD_INT
                 : fpsvh_pkg::FPSVH_OP_TRANSC;
            if (i == 2) r.a = rnd_nan(1'b0);
            r.int_at_min = 1'b1; r.int_size = 2'd2;
            send(r);
            rd(fpsvh_pkg::OFS_STATUS, d); chk(d[0], 1'b0);
        end
        r = '0; r.op = fpsvh_pkg::FPSVH_OP_ARITH; r.other_invalid = 1'b1;
        send(r); chk(rsp_o.res, {1'b1, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_IND});
        r.other_invalid = 1'b0; r.a = {1'b1, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_IND};
        send(r); chk(rsp_o.res, r.a);
        for (int i = 0; i < 4; i++) begin
            wr(fpsvh_pkg::OFS_STATUS, 32'h3f);
            sz = i[1:0];
            r = '0; r.other_invalid = (sz != 2'd3); r.int_size = (sz == 2'd3) ? 2'd0 : sz;
            r.op = (sz == 2'd3) ? fpsvh_pkg::FPSVH_OP_STORE_PD : fpsvh_pkg::FPSVH_OP_STORE_INT;
            r.other_invalid = 1'b1;
            send(r); chk(rsp_o.write_en, 1'b1);
            if (sz == 2'd3) chk(rsp_o.mem_data[79:64], fpsvh_pkg::PD_IND_TOP);
            else chk(rsp_o.mem_data, {16'h0, int_min(sz)});
            rd(fpsvh_pkg::OFS_STATUS, d); chk(d[0], 1'b1);
        end
        for (int i = 0; i < 8; i++) begin
            wr(fpsvh_pkg::OFS_STATUS, 32'h3f);
            wr(fpsvh_pkg::OFS_CTRL, i[1] ? 32'h2 : 32'h1);
            r = '0; r.op = fpsvh_pkg::FPSVH_OP_ARITH; r.overflow = 1'b1; r.inexact = 1'b1;
            r.rounded = {i[0], 15'h7000, (i[2] ? 64'h0 : 64'h8000_0000_0000_0000) | 64'($urandom())};
            send(r); chk(rsp_o.res, ovf_res(i[1], i[0], r.rounded.sig));
            rd(fpsvh_pkg::OFS_STATUS, d); chk({d[3], d[5]}, 2'b01);
        end
        wr(fpsvh_pkg::OFS_STATUS, 32'h3f);
        wr(fpsvh_pkg::OFS_MASK, 32'h37);
        r = '0; r.op = fpsvh_pkg::FPSVH_OP_STORE_REAL; r.overflow = 1'b1;
        send(r); chk(rsp_o.write_en, 1'b0);
        wr(fpsvh_pkg::OFS_MASK, 32'h2f);
        r.overflow = 1'b0; r.underflow = 1'b1;
        send(r); chk(rsp_o.write_en, 1'b0);
        chk(irq_o, 1'b1);
        wr(fpsvh_pkg::OFS_MASK, 32'h3f);
        @(posedge clk_i); #1 chk(irq_o, 1'b0);
        wr(fpsvh_pkg::OFS_STATUS, 32'h3f);
        wr(fpsvh_pkg::OFS_MASK, 32'h3e);
        r = '0; r.op = fpsvh_pkg::FPSVH_OP_ARITH; r.a = rnd_nan(1'b1); r.a_addr = 20'($urandom());
        send(r); chk(rsp_o.trap, 1'b1);
        rd(fpsvh_pkg::OFS_EPTR, d); chk(d[19:0], r.a_addr);
        rd(fpsvh_pkg::OFS_CLASS, d); chk(d[2:0], fpsvh_pkg::FPSVH_CL_NAN);
        wr(fpsvh_pkg::OFS_STATUS, 32'h3f);
        @(posedge clk_i); #1 chk(irq_o, 1'b0);
        end_sim();
    end
endmodule

`default_nettype wire

// ===== hw/fpsvh_pkg.sv
// fpsvh_pkg: constants and carrier types for the special-value handler
// assumes temporary-real (80-bit) internal operands with explicit integer bit
package fpsvh_pkg;

    // ------------------------------------------------------------------
    // temporary real layout
    // ------------------------------------------------------------------
    localparam int TR_W       = 80;
    localparam int EXP_W      = 15;
    localparam int SIG_W      = 64;
    localparam logic [EXP_W-1:0] EXP_ONES = 15'h7fff;
    localparam logic [EXP_W-1:0] EXP_MAXF = 15'h7ffe;
    localparam logic [EXP_W-1:0] EXP_ZERO = 15'h0000;
    localparam logic [SIG_W-1:0] SIG_INF  = 64'h8000_0000_0000_0000;
    localparam logic [SIG_W-1:0] SIG_IND  = 64'hc000_0000_0000_0000;
    localparam logic [SIG_W-1:0] SIG_MAXF = 64'hffff_ffff_ffff_fffe;
    localparam logic [SIG_W-1:0] SIG_ZERO = 64'h0000_0000_0000_0000;

    // ------------------------------------------------------------------
    // short and long real layout (integer bit implied)
    // ------------------------------------------------------------------
    localparam int SR_EXP_W  = 8;
    localparam int SR_FRAC_W = 23;
    localparam int LR_EXP_W  = 11;
    localparam int LR_FRAC_W = 52;
    localparam logic [SR_EXP_W-1:0] SR_EXP_ONES = 8'hff;
    localparam logic [LR_EXP_W-1:0] LR_EXP_ONES = 11'h7ff;
    localparam logic [SR_EXP_W-1:0] SR_EXP_ZERO = 8'h00;
    localparam logic [LR_EXP_W-1:0] LR_EXP_ZERO = 11'h000;

    // packed decimal: sign byte plus 9 digit bytes
    localparam int PD_W = 80;
    localparam logic [15:0] PD_IND_TOP = 16'hffff;

    // status / mask bit positions
    localparam int ST_W       = 6;
    localparam int ST_INVALID = 0;
    localparam int ST_DENORM  = 1;
    localparam int ST_ZDIV    = 2;
    localparam int ST_OVFL    = 3;
    localparam int ST_UNFL    = 4;
    localparam int ST_PREC    = 5;

    // register port offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_EPTR   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CLASS  = 4'h4;
    localparam int DATA_W = 32;
    localparam logic [ST_W-1:0] MASK_RESET = 6'h3f;
    localparam logic [1:0]      RC_RESET   = 2'h0;

    typedef enum logic [1:0] {
        FPSVH_RC_NEAREST = 2'b00,
        FPSVH_RC_DOWN    = 2'b01,
        FPSVH_RC_UP      = 2'b10,
        FPSVH_RC_CHOP    = 2'b11
    } fpsvh_rc_t;

    typedef enum logic [2:0] {
        FPSVH_CL_ZERO   = 3'b000,
        FPSVH_CL_DENORM = 3'b001,
        FPSVH_CL_UNNORM = 3'b010,
        FPSVH_CL_NORMAL = 3'b011,
        FPSVH_CL_INF    = 3'b100,
        FPSVH_CL_NAN    = 3'b101,
        FPSVH_CL_INDEF  = 3'b110
    } fpsvh_class_t;

    typedef enum logic [2:0] {
        FPSVH_OP_ARITH     = 3'b000,
        FPSVH_OP_TRANSC    = 3'b001,
        FPSVH_OP_STORE_REAL= 3'b010,
        FPSVH_OP_STORE_INT = 3'b011,
        FPSVH_OP_STORE_PD  = 3'b100,
        FPSVH_OP_LOAD_INT  = 3'b101,
        FPSVH_OP_LOAD_PD   = 3'b110
    } fpsvh_op_t;

    typedef struct packed {
        logic             sign;
        logic [EXP_W-1:0] exp;
        logic [SIG_W-1:0] sig;
    } fpsvh_treal_t;

    // one request from the datapath: operands plus the raw exception findings
    typedef struct packed {
        fpsvh_op_t    op;
        fpsvh_treal_t a;
        fpsvh_treal_t b;
        logic         two_ops;
        logic         other_invalid;
        logic         overflow;
        logic         underflow;
        logic         inexact;
        fpsvh_treal_t rounded;
        logic [19:0]  a_addr;
        logic [63:0]  int_in;
        logic [1:0]   int_size;
        logic         int_at_min;
    } fpsvh_req_t;

    typedef struct packed {
        fpsvh_treal_t res;
        logic [79:0]  mem_data;
        logic         write_en;
        logic         trap;
    } fpsvh_rsp_t;

endpackage

// ===== hw/fpsvh_top.sv
// fpsvh_top: special-value classification, nan propagation, masked responses
// assumes requests come from same-clock datapath logic, one per cycle
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module fpsvh_top #(
    parameter int EPTR_W = 20
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    // register port
    input  wire logic [fpsvh_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [fpsvh_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic [fpsvh_pkg::DATA_W-1:0]    reg_rdata_o,
    // datapath request and response
    input  wire logic                       req_valid_i,
    input  wire fpsvh_pkg::fpsvh_req_t      req_i,
    output logic                            rsp_valid_o,
    output fpsvh_pkg::fpsvh_rsp_t           rsp_o,
    // interrupt
    output logic                            irq_o
);

    // ------------------------------------------------------------------
    // operand classification
    // ------------------------------------------------------------------
    function automatic fpsvh_pkg::fpsvh_class_t classify(input fpsvh_pkg::fpsvh_treal_t v);
        if (v.exp == fpsvh_pkg::EXP_ONES) begin
            if (v.sig == fpsvh_pkg::SIG_INF)
                classify = fpsvh_pkg::FPSVH_CL_INF;
            else if (v.sign && v.sig == fpsvh_pkg::SIG_IND)
                classify = fpsvh_pkg::FPSVH_CL_INDEF;
            else
                classify = fpsvh_pkg::FPSVH_CL_NAN;
        end else if (v.exp == fpsvh_pkg::EXP_ZERO) begin
            classify = (v.sig == fpsvh_pkg::SIG_ZERO) ? fpsvh_pkg::FPSVH_CL_ZERO
                                                      : fpsvh_pkg::FPSVH_CL_DENORM;
        end else begin
            classify = v.sig[fpsvh_pkg::SIG_W-1] ? fpsvh_pkg::FPSVH_CL_NORMAL
                                                 : fpsvh_pkg::FPSVH_CL_UNNORM;
        end
    endfunction

    wire fpsvh_pkg::fpsvh_class_t cls_a = classify(req_i.a);
    wire fpsvh_pkg::fpsvh_class_t cls_b = classify(req_i.b);
    wire logic nan_a = (cls_a == fpsvh_pkg::FPSVH_CL_NAN) || (cls_a == fpsvh_pkg::FPSVH_CL_INDEF);
    wire logic nan_b = req_i.two_ops &&
                       ((cls_b == fpsvh_pkg::FPSVH_CL_NAN) || (cls_b == fpsvh_pkg::FPSVH_CL_INDEF));

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [fpsvh_pkg::ST_W-1:0] status_reg;
    logic [fpsvh_pkg::ST_W-1:0] status_next;
    logic [fpsvh_pkg::ST_W-1:0] mask_reg;
    logic [1:0]                 rc_reg;
    logic [EPTR_W-1:0]          eptr_reg;
    logic [2:0]                 last_class_reg;

    wire fpsvh_pkg::fpsvh_rc_t rc = fpsvh_pkg::fpsvh_rc_t'(rc_reg);
    wire logic inv_masked  = mask_reg[fpsvh_pkg::ST_INVALID];
    wire logic ovf_masked  = mask_reg[fpsvh_pkg::ST_OVFL];
    wire logic unf_masked  = mask_reg[fpsvh_pkg::ST_UNFL];
    wire logic directed    = (rc == fpsvh_pkg::FPSVH_RC_UP) || (rc == fpsvh_pkg::FPSVH_RC_DOWN);

    // ------------------------------------------------------------------
    // exception detection
    // ------------------------------------------------------------------
    wire logic is_transc  = (req_i.op == fpsvh_pkg::FPSVH_OP_TRANSC);
    wire logic is_load    = (req_i.op == fpsvh_pkg::FPSVH_OP_LOAD_INT) ||
                            (req_i.op == fpsvh_pkg::FPSVH_OP_LOAD_PD);
    // transcendentals raise no flag from operand class; only the class register records it
    wire logic nan_seen   = !is_transc && !is_load && (nan_a || nan_b);
    wire logic invalid    = nan_seen || (!is_transc && req_i.other_invalid);
    wire logic is_st_real = (req_i.op == fpsvh_pkg::FPSVH_OP_STORE_REAL);
    wire logic ovf_dir    = req_i.overflow && ovf_masked && directed;
    wire logic st_blocked = is_st_real && ((req_i.overflow && !ovf_masked) ||
                                           (req_i.underflow && !unf_masked));
    wire logic trap_inv   = invalid && !inv_masked;

    // larger magnitude nan, signs ignored
    wire logic [fpsvh_pkg::EXP_W+fpsvh_pkg::SIG_W-1:0] mag_a = {req_i.a.exp, req_i.a.sig};
    wire logic [fpsvh_pkg::EXP_W+fpsvh_pkg::SIG_W-1:0] mag_b = {req_i.b.exp, req_i.b.sig};
    wire fpsvh_pkg::fpsvh_treal_t nan_pick =
        (nan_a && nan_b) ? ((mag_b > mag_a) ? req_i.b : req_i.a)
                         : (nan_a ? req_i.a : req_i.b);

    wire fpsvh_pkg::fpsvh_treal_t real_indef = '{sign: 1'b1,
                                                 exp:  fpsvh_pkg::EXP_ONES,
                                                 sig:  fpsvh_pkg::SIG_IND};

    // directed-rounding overflow result
    wire logic r_sign   = req_i.rounded.sign;
    wire logic to_inf   = (rc == fpsvh_pkg::FPSVH_RC_UP) ? !r_sign : r_sign;
    wire logic r_unnorm = !req_i.rounded.sig[fpsvh_pkg::SIG_W-1];
    // an unnormal keeps its own significand, so it stays unnormal
    wire fpsvh_pkg::fpsvh_treal_t ovf_res =
        to_inf   ? {r_sign, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_INF}
      : r_unnorm ? {r_sign, fpsvh_pkg::EXP_MAXF, req_i.rounded.sig}
                 : {r_sign, fpsvh_pkg::EXP_MAXF, fpsvh_pkg::SIG_MAXF};

    // ------------------------------------------------------------------
    // memory images (low bits at low byte addresses, sign at top)
    // ------------------------------------------------------------------
    wire logic int_indef = invalid && inv_masked;
    wire logic [63:0] int_min64 = 64'h8000_0000_0000_0000;
    wire logic [79:0] int_img =
        (req_i.int_size == 2'h0) ? {64'h0, int_min64[63:48]} :
        (req_i.int_size == 2'h1) ? {48'h0, int_min64[63:32]} :
                                   {16'h0, int_min64};
    wire logic [79:0] pd_img = {fpsvh_pkg::PD_IND_TOP, req_i.int_in};
    wire logic [79:0] real_img = {req_i.rounded.sign, req_i.rounded.exp,
                                  req_i.rounded.sig};

    // ------------------------------------------------------------------
    // result selection
    // ------------------------------------------------------------------
    fpsvh_pkg::fpsvh_rsp_t rsp_next;
    always_comb begin
        rsp_next          = '0;
        rsp_next.res      = req_i.rounded;
        rsp_next.mem_data = real_img;
        rsp_next.write_en = 1'b1;
        rsp_next.trap     = trap_inv;
        unique case (req_i.op)
            fpsvh_pkg::FPSVH_OP_TRANSC: begin
                rsp_next.res = req_i.rounded;
            end
            fpsvh_pkg::FPSVH_OP_STORE_INT: begin
                if (int_indef || req_i.int_at_min)
                    rsp_next.mem_data = int_img;
                else
                    rsp_next.mem_data = {16'h0, req_i.int_in};
                rsp_next.write_en = !trap_inv;
            end
            fpsvh_pkg::FPSVH_OP_STORE_PD: begin
                rsp_next.mem_data = int_indef ? pd_img : {16'h0, req_i.int_in};
                rsp_next.write_en = !trap_inv;
            end
            fpsvh_pkg::FPSVH_OP_LOAD_INT, fpsvh_pkg::FPSVH_OP_LOAD_PD: begin
                // the sign-one zero-magnitude integer stays a plain number
                rsp_next.res = req_i.rounded;
            end
            default: begin
                if (invalid && inv_masked)
                    rsp_next.res = nan_seen ? nan_pick : real_indef;
                else if (ovf_dir)
                    rsp_next.res = ovf_res;
                if (is_st_real) begin
                    rsp_next.mem_data = {rsp_next.res.sign, rsp_next.res.exp, rsp_next.res.sig};
                    rsp_next.write_en = !st_blocked && !trap_inv;
                end else begin
                    rsp_next.write_en = !trap_inv;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // status flags: hardware set wins over write-one-to-clear
    // ------------------------------------------------------------------
    logic [fpsvh_pkg::ST_W-1:0] ev_set;
    // zero-divide is never raised here: no divider sits in this block
    always_comb begin
        ev_set = '0;
        if (req_valid_i) begin
            ev_set[fpsvh_pkg::ST_INVALID] = invalid;
            ev_set[fpsvh_pkg::ST_OVFL]    = req_i.overflow && !ovf_dir;
            ev_set[fpsvh_pkg::ST_UNFL]    = req_i.underflow;
            ev_set[fpsvh_pkg::ST_PREC]    = req_i.inexact || ovf_dir;
            ev_set[fpsvh_pkg::ST_DENORM]  = !is_transc &&
                                            (cls_a == fpsvh_pkg::FPSVH_CL_DENORM);
        end
    end

    wire logic wr_status = reg_wr_i && (reg_addr_i == fpsvh_pkg::OFS_STATUS);
    wire logic wr_mask   = reg_wr_i && (reg_addr_i == fpsvh_pkg::OFS_MASK);
    wire logic wr_ctrl   = reg_wr_i && (reg_addr_i == fpsvh_pkg::OFS_CTRL);
    wire logic [fpsvh_pkg::ST_W-1:0] w1c = wr_status ? reg_wdata_i[fpsvh_pkg::ST_W-1:0] : '0;
    wire logic [fpsvh_pkg::ST_W-1:0] mask_next = wr_mask ? reg_wdata_i[fpsvh_pkg::ST_W-1:0] : mask_reg;
    assign status_next = (status_reg & ~w1c) | ev_set;

    wire logic rec_ptr = req_valid_i && nan_seen && !inv_masked;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_reg     <= '0;
            mask_reg       <= fpsvh_pkg::MASK_RESET;
            rc_reg         <= fpsvh_pkg::RC_RESET;
            eptr_reg       <= '0;
            last_class_reg <= '0;
        end else begin
            status_reg <= status_next;
            if (wr_mask)
                mask_reg <= reg_wdata_i[fpsvh_pkg::ST_W-1:0];
            if (wr_ctrl)
                rc_reg <= reg_wdata_i[1:0];
            if (rec_ptr)
                eptr_reg <= req_i.a_addr[EPTR_W-1:0];
            if (req_valid_i)
                last_class_reg <= cls_a;
        end
    end

    // ------------------------------------------------------------------
    // register read mux, response and interrupt
    // ------------------------------------------------------------------
    logic [fpsvh_pkg::DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr_i)
            fpsvh_pkg::OFS_STATUS: rd_mux[fpsvh_pkg::ST_W-1:0] = status_reg;
            fpsvh_pkg::OFS_MASK:   rd_mux[fpsvh_pkg::ST_W-1:0] = mask_reg;
            fpsvh_pkg::OFS_CTRL:   rd_mux[1:0]                 = rc_reg;
            fpsvh_pkg::OFS_EPTR:   rd_mux[EPTR_W-1:0]          = eptr_reg;
            fpsvh_pkg::OFS_CLASS:  rd_mux[2:0]                 = last_class_reg;
            default:               rd_mux                      = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
            irq_o       <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : '0;
            rsp_valid_o <= req_valid_i;
            rsp_o       <= req_valid_i ? rsp_next : rsp_o;
            // next mask too, so the level never lags a mask write by a cycle
            irq_o       <= |(status_next & ~mask_next);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_nan_sets_invalid: assert property (
        req_valid_i && nan_seen |=> status_reg[fpsvh_pkg::ST_INVALID])
        else $error("nan operand did not set invalid");
    a_inf_not_nan: assert property (
        req_i.a.exp == fpsvh_pkg::EXP_ONES && req_i.a.sig == fpsvh_pkg::SIG_INF
        |-> cls_a == fpsvh_pkg::FPSVH_CL_INF)
        else $error("infinity classed wrongly");
    a_nan_class: assert property (
        req_i.a.exp == fpsvh_pkg::EXP_ONES && req_i.a.sig != fpsvh_pkg::SIG_INF
        |-> nan_a)
        else $error("nan classed wrongly");
    a_indef_result: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_ARITH && inv_masked
        && !nan_seen && req_i.other_invalid
        |=> rsp_o.res == {1'b1, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_IND})
        else $error("real indefinite not returned");
    a_nan_larger: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_ARITH && inv_masked && nan_a && nan_b
        |=> {rsp_o.res.exp, rsp_o.res.sig} == (($past(mag_a) > $past(mag_b)) ? $past(mag_a) : $past(mag_b)))
        else $error("wrong nan chosen");
    a_st_no_write: assert property (
        req_valid_i && st_blocked |=> rsp_valid_o && !rsp_o.write_en)
        else $error("blocked store still wrote");
    a_dir_ovf_flags: assert property (
        req_valid_i && ovf_dir && !(status_reg[fpsvh_pkg::ST_OVFL])
        |=> status_reg[fpsvh_pkg::ST_PREC] && !status_reg[fpsvh_pkg::ST_OVFL])
        else $error("directed overflow flags wrong");
    a_int_indef_flag: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_STORE_INT && int_indef
        |=> status_reg[fpsvh_pkg::ST_INVALID] && rsp_o.mem_data == $past(int_img))
        else $error("integer indefinite without invalid");
    a_ptr_record: assert property (
        rec_ptr |=> eptr_reg == $past(req_i.a_addr[EPTR_W-1:0]))
        else $error("operand address not recorded");
    a_irq_level: assert property (
        irq_o == |(status_reg & ~mask_reg))
        else $error("interrupt does not follow status");

    // result checks look one edge on, where rsp_o is registered
    a_transc_pass: assert property (
        req_valid_i && is_transc
        |=> rsp_o.res == $past(req_i.rounded) && !rsp_o.trap)
        else $error("transcendental result not passed through");

    a_load_number: assert property (
        req_valid_i && is_load
        |=> rsp_o.res == $past(req_i.rounded))
        else $error("integer load result altered");

    a_pd_indef: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_STORE_PD && int_indef
        |=> rsp_o.mem_data[fpsvh_pkg::PD_W-1 -: $bits(fpsvh_pkg::PD_IND_TOP)] == fpsvh_pkg::PD_IND_TOP)
        else $error("packed indefinite not stored");

    a_int_min_store: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_STORE_INT && req_i.int_at_min && !trap_inv
        |=> rsp_o.write_en && rsp_o.mem_data == $past(int_img))
        else $error("most negative integer not stored");

    a_dir_up_inf: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_ARITH && !invalid && ovf_dir
        && rc == fpsvh_pkg::FPSVH_RC_UP && !req_i.rounded.sign
        |=> rsp_o.res == {1'b0, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_INF})
        else $error("directed overflow missed infinity");

    a_unnorm_kept: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_ARITH && !invalid && ovf_dir
        && r_unnorm && !to_inf
        |=> rsp_o.res.exp == fpsvh_pkg::EXP_MAXF && rsp_o.res.sig == $past(req_i.rounded.sig))
        else $error("unnormal overflow lost its significand");

    a_indef_as_nan: assert property (
        req_valid_i && req_i.op == fpsvh_pkg::FPSVH_OP_ARITH && inv_masked
        && cls_a == fpsvh_pkg::FPSVH_CL_INDEF && !req_i.two_ops
        |=> rsp_o.res == {1'b1, fpsvh_pkg::EXP_ONES, fpsvh_pkg::SIG_IND})
        else $error("real indefinite not propagated");

    a_trap_no_write: assert property (
        req_valid_i && (req_i.op == fpsvh_pkg::FPSVH_OP_STORE_INT || req_i.op == fpsvh_pkg::FPSVH_OP_STORE_PD)
        && trap_inv |=> !rsp_o.write_en)
        else $error("trapped integer store still wrote");

    a_rsp_pulse: assert property (
        rsp_valid_o == $past(req_valid_i))
        else $error("response valid not one cycle after request");

    a_rdata_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data stood past its cycle");

    c_nan_prop:   cover property (req_valid_i && nan_a && nan_b && inv_masked);
    c_unnorm_ovf: cover property (req_valid_i && ovf_dir && r_unnorm && !to_inf);
    c_dir_ovf:    cover property (req_valid_i && ovf_dir && to_inf);
    c_blocked:    cover property (req_valid_i && st_blocked);
    c_int_indef:  cover property (req_valid_i && int_indef && req_i.op == fpsvh_pkg::FPSVH_OP_STORE_INT);

endmodule

`default_nettype wire
